// ---- src/logic_counter_bank_pkg.sv ----
package logic_counter_bank_pkg;

  localparam int NUM_COUNTERS = 32;
  localparam int NUM_VARIABLES = 32;
  localparam int COUNT_W = 16;
  localparam int DELAY_W = 20;
  localparam int DELAY_MAX_CS = 300000;
  localparam int TICK_US = 1000;
  localparam int CLK_MHZ = 125;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_DISABLE = 32'h0000_0008;
  localparam logic [31:0] ADDR_UP_NA = 32'h0000_000C;
  localparam logic [31:0] ADDR_DOWN_NA = 32'h0000_0010;
  localparam logic [31:0] ADDR_AT_ZERO = 32'h0000_0014;
  localparam logic [31:0] ADDR_AT_PRESET = 32'h0000_0018;
  localparam logic [31:0] ADDR_QUERY_SEL = 32'h0000_001C;
  localparam logic [31:0] ADDR_QUERY_VAL = 32'h0000_0020;

  localparam int CTRL_SETTINGS_BIT = 0;
  localparam int STATUS_CLEARED_BIT = 0;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic clear;
    logic load;
    logic up;
    logic down;
  } counter_ctrl_t;

endpackage : logic_counter_bank_pkg

// ---- src/logic_counter_bank.sv ----
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - power-up or settings change clears all variable and timer outputs.
// - thirty-two variables, each with pickup and dropout delays up to 3000.00.
// - thirty-two up/down counters, re-evaluated once per processing interval.
// - at-zero flag is high exactly when count equals zero.
// - at-preset flag is high exactly when an enabled counter's count equals preset.
// - load held high sets count to preset.
// - rising edge on up adds one below preset; rising edge on down subtracts one above zero.
// - clear held high forces count to zero.
// - priority is clear, then load, then up edge, then down edge.
// - load is ignored while clear is high.
// - up and down edges are discarded while clear or load is high.
// - simultaneous edges count up, unless already at or above preset, then down.
// - held levels count once; levels surviving clear or load are no edge.
// - count and flags update in the interval the edge is first seen.
// - disabled counter holds zero, at-zero high, at-preset low.
// - down input not assigned disables the whole counter.
// - up input not assigned makes a down-only counter.
// - each count is a numeric output, also readable by query.
module logic_counter_bank #(
  parameter int N = logic_counter_bank_pkg::NUM_COUNTERS,
  parameter int W = logic_counter_bank_pkg::COUNT_W,
  parameter int V = logic_counter_bank_pkg::NUM_VARIABLES,
  parameter int DW = logic_counter_bank_pkg::DELAY_W,
  parameter int TICK_CYCLES = logic_counter_bank_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter control equations
  input wire logic_counter_bank_pkg::counter_ctrl_t [N-1:0] counter_ctrl,
  input wire logic [N-1:0][W-1:0] counter_preset_value,
  // variable equations and delays in processing intervals
  input wire logic [V-1:0] variable_in,
  input wire logic [V-1:0][DW-1:0] timer_pickup_delay,
  input wire logic [V-1:0][DW-1:0] timer_dropout_delay,
  // counter results
  output logic [N-1:0][W-1:0] count_value_out,
  output logic [N-1:0] at_zero_flag,
  output logic [N-1:0] at_preset_flag,
  // variable results
  output logic [V-1:0] logic_variable_out,
  output logic [V-1:0] variable_timer_out,
  // one cycle per processing interval
  output logic interval_tick
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int QW = $clog2(N);
  localparam logic [DW-1:0] DELAY_TOP =
    DW'(logic_counter_bank_pkg::DELAY_MAX_CS);

  // processing interval strobe
  logic [TW-1:0] tick_cnt;
  wire tick_now = (tick_cnt == TW'(TICK_CYCLES - 1));
  wire [TW-1:0] next_tick_cnt = tick_now ? '0 : tick_cnt + TW'(1);

  always_ff @(posedge clk or posedge rst)
    if (rst)
      tick_cnt <= '0;
    else
      tick_cnt <= next_tick_cnt;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      interval_tick <= 1'h0;
    else
      interval_tick <= tick_now;

  // configuration registers
  logic [N-1:0] disable_cfg;
  logic [N-1:0] up_na;
  logic [N-1:0] down_na;
  logic [QW-1:0] query_sel;
  logic settings_pulse;
  logic cleared_seen;

  // writes land at the completing edge, the one with pready high
  wire apb_access = psel && penable;
  wire apb_done = apb_access && pready;
  wire apb_wr = apb_done && pwrite;
  wire wr_ctrl = apb_wr && paddr == logic_counter_bank_pkg::ADDR_CTRL;
  wire wr_dis = apb_wr && paddr == logic_counter_bank_pkg::ADDR_DISABLE;
  wire wr_upna = apb_wr && paddr == logic_counter_bank_pkg::ADDR_UP_NA;
  wire wr_dnna = apb_wr && paddr == logic_counter_bank_pkg::ADDR_DOWN_NA;
  wire wr_qsel = apb_wr && paddr == logic_counter_bank_pkg::ADDR_QUERY_SEL;
  // disable, up and down not-assigned writes, or a ctrl write with the settings bit, count as a settings change
  wire settings_change = wr_dis || wr_upna || wr_dnna ||
    (wr_ctrl && pwdata[logic_counter_bank_pkg::CTRL_SETTINGS_BIT]);

  // one short block per register keeps each write path readable
  always_ff @(posedge clk or posedge rst)
    if (rst)
      disable_cfg <= '0;
    else if (wr_dis)
      disable_cfg <= pwdata[N-1:0];

  always_ff @(posedge clk or posedge rst)
    if (rst)
      up_na <= '0;
    else if (wr_upna)
      up_na <= pwdata[N-1:0];

  always_ff @(posedge clk or posedge rst)
    if (rst)
      down_na <= '0;
    else if (wr_dnna)
      down_na <= pwdata[N-1:0];

  always_ff @(posedge clk or posedge rst)
    if (rst)
      query_sel <= '0;
    else if (wr_qsel)
      query_sel <= pwdata[QW-1:0];

  // the clear lands one cycle after the write that asks for it
  always_ff @(posedge clk or posedge rst)
    if (rst)
      settings_pulse <= 1'h0;
    else
      settings_pulse <= settings_change;

  // sticky mark that a clear happened; set wins over software clear
  wire clr_status = apb_wr && paddr == logic_counter_bank_pkg::ADDR_STATUS;
  wire clr_bit = pwdata[logic_counter_bank_pkg::STATUS_CLEARED_BIT];
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cleared_seen <= 1'h1;
    else if (settings_pulse)
      cleared_seen <= 1'h1;
    else if (clr_status && clr_bit)
      cleared_seen <= 1'h0;

  // counters
  logic [N-1:0] prev_up;
  logic [N-1:0] prev_down;
  logic [N-1:0][W-1:0] count;

  function automatic logic [W-1:0] next_count_f(
    input logic [W-1:0] cur,
    input logic [W-1:0] pv,
    input logic_counter_bank_pkg::counter_ctrl_t c,
    input logic up_edge,
    input logic dn_edge,
    input logic off
  );
    logic [W-1:0] res;
    res = cur;
    if (off)
      res = '0;
    else if (c.clear)
      res = '0;
    else if (c.load)
      res = pv;
    else if (up_edge && cur != pv && cur < pv)
      res = cur + W'(1);
    else if (dn_edge && cur != '0)
      res = cur - W'(1);
    return res;
  endfunction : next_count_f

  // a level counts once, on the first interval that sees it high
  function automatic logic rise_f(
    input logic lvl,
    input logic prev
  );
    return lvl && !prev;
  endfunction : rise_f

  for (genvar i = 0; i < N; i++)
  begin : g_counter
    wire counter_off = disable_cfg[i] || down_na[i];
    wire up_lvl = counter_ctrl[i].up && !up_na[i];
    wire dn_lvl = counter_ctrl[i].down;
    // edges seen under clear or load are consumed, not deferred
    wire up_edge = rise_f(up_lvl, prev_up[i]);
    wire dn_edge = rise_f(dn_lvl, prev_down[i]);
    wire [W-1:0] next_count = next_count_f(count[i],
      counter_preset_value[i], counter_ctrl[i], up_edge, dn_edge,
      counter_off);
    wire next_zero = next_count == '0;
    wire next_top = !counter_off &&
      next_count == counter_preset_value[i];

    // edge history runs while disabled, so enabling sees no false edge
    always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
        count[i] <= '0;
        prev_up[i] <= 1'h0;
        prev_down[i] <= 1'h0;
      end
      else if (tick_now)
      begin
        count[i] <= next_count;
        prev_up[i] <= up_lvl;
        prev_down[i] <= dn_lvl;
      end

    always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
        count_value_out[i] <= '0;
        at_zero_flag[i] <= 1'h1;
        at_preset_flag[i] <= 1'h0;
      end
      else if (tick_now)
      begin
        count_value_out[i] <= next_count;
        at_zero_flag[i] <= next_zero;
        at_preset_flag[i] <= next_top;
      end
  end

  // settings past the top of the range are held at the top
  function automatic logic [DW-1:0] clamp_delay_f(
    input logic [DW-1:0] d
  );
    return d > DELAY_TOP ? DELAY_TOP : d;
  endfunction : clamp_delay_f

  // variables with pickup and dropout timers
  logic [V-1:0][DW-1:0] timer_cnt;
  for (genvar j = 0; j < V; j++)
  begin : g_variable
    wire lvl = variable_in[j];
    wire timing = lvl != variable_timer_out[j];
    wire [DW-1:0] pickup = clamp_delay_f(timer_pickup_delay[j]);
    wire [DW-1:0] dropout = clamp_delay_f(timer_dropout_delay[j]);
    wire [DW-1:0] target = lvl ? pickup : dropout;
    wire done = timer_cnt[j] >= target;
    wire [DW-1:0] next_timer_cnt = (!timing || done) ? '0 :
      timer_cnt[j] + DW'(1);

    always_ff @(posedge clk or posedge rst)
      if (rst)
        timer_cnt[j] <= '0;
      else if (settings_pulse)
        timer_cnt[j] <= '0;
      else if (tick_now)
        timer_cnt[j] <= next_timer_cnt;

    always_ff @(posedge clk or posedge rst)
      if (rst)
        logic_variable_out[j] <= 1'h0;
      else if (settings_pulse)
        logic_variable_out[j] <= 1'h0;
      else if (tick_now)
        logic_variable_out[j] <= lvl;

    // a clear wins over a timer that expires in the same cycle
    always_ff @(posedge clk or posedge rst)
      if (rst)
        variable_timer_out[j] <= 1'h0;
      else if (settings_pulse)
        variable_timer_out[j] <= 1'h0;
      else if (tick_now && timing && done)
        variable_timer_out[j] <= lvl;
  end

  // delays counted in intervals; the interval stands in for 10 ms units
  // so a 1 ms interval gives ten times finer timing than printed

  // read decode
  wire [31:0] rd_query = 32'(count[query_sel]);
  wire [31:0] rd_data =
    paddr == logic_counter_bank_pkg::ADDR_STATUS ? 32'(cleared_seen) :
    paddr == logic_counter_bank_pkg::ADDR_DISABLE ? 32'(disable_cfg) :
    paddr == logic_counter_bank_pkg::ADDR_UP_NA ? 32'(up_na) :
    paddr == logic_counter_bank_pkg::ADDR_DOWN_NA ? 32'(down_na) :
    paddr == logic_counter_bank_pkg::ADDR_AT_ZERO ? 32'(at_zero_flag) :
    paddr == logic_counter_bank_pkg::ADDR_AT_PRESET ? 32'(at_preset_flag) :
    paddr == logic_counter_bank_pkg::ADDR_QUERY_SEL ? 32'(query_sel) :
    paddr == logic_counter_bank_pkg::ADDR_QUERY_VAL ? rd_query :
    logic_counter_bank_pkg::RESET_ZERO;
  wire addr_ok = paddr == logic_counter_bank_pkg::ADDR_CTRL ||
    paddr == logic_counter_bank_pkg::ADDR_STATUS ||
    paddr == logic_counter_bank_pkg::ADDR_DISABLE ||
    paddr == logic_counter_bank_pkg::ADDR_UP_NA ||
    paddr == logic_counter_bank_pkg::ADDR_DOWN_NA ||
    paddr == logic_counter_bank_pkg::ADDR_AT_ZERO ||
    paddr == logic_counter_bank_pkg::ADDR_AT_PRESET ||
    paddr == logic_counter_bank_pkg::ADDR_QUERY_SEL ||
    paddr == logic_counter_bank_pkg::ADDR_QUERY_VAL;

  // registered answer: pready rises in the second access cycle
  wire answer_now = psel && penable && !pready;
  wire read_now = answer_now && !pwrite;
  wire error_now = answer_now && !addr_ok;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      pready <= 1'h0;
    else
      pready <= answer_now;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      pslverr <= 1'h0;
    else
      pslverr <= error_now;

  // read data is zero outside its one answer cycle
  always_ff @(posedge clk or posedge rst)
    if (rst)
      prdata <= '0;
    else
      prdata <= read_now ? rd_data : '0;

endmodule : logic_counter_bank

// ---- tb/logic_counter_bank_monitor.sv ----
`timescale 1ns/100ps
module logic_counter_bank_monitor #(
  parameter int N = 32,
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // counters
  input wire logic_counter_bank_pkg::counter_ctrl_t [N-1:0] counter_ctrl,
  input wire logic [N-1:0][W-1:0] counter_preset_value,
  input wire logic [N-1:0][W-1:0] count_value_out,
  input wire logic [N-1:0] at_zero_flag,
  input wire logic [N-1:0] at_preset_flag,
  input wire logic interval_tick
);
  // counter 0 only: the bench never disables it
  logic up_q;
  logic dn_q;
  wire logic tk = interval_tick;
  wire logic [W-1:0] q = count_value_out[0];
  wire logic [W-1:0] p = counter_preset_value[0];
  wire logic hold = !counter_ctrl[0].clear && !counter_ctrl[0].load;
  wire logic ue = counter_ctrl[0].up && !up_q;
  wire logic de = counter_ctrl[0].down && !dn_q;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      {up_q, dn_q} <= 2'h0;
    else if (tk)
      {up_q, dn_q} <= {counter_ctrl[0].up, counter_ctrl[0].down};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_zero_flag: assert property (at_zero_flag[0] == (q == '0))
    else $error("at-zero flag wrong");
  a_preset_flag: assert property (at_preset_flag[0] == (q == p))
    else $error("at-preset flag wrong");
  a_clear_zero: assert property (tk && counter_ctrl[0].clear |-> q == '0)
    else $error("clear did not zero");
  a_load_preset: assert property (tk && hold == 1'h0 && !counter_ctrl[0].clear
    |-> q == p)
    else $error("load did not set preset");
  a_quiet_hold: assert property (!tk |-> $stable(q))
    else $error("count moved between intervals");
  a_up_step: assert property (tk && hold && ue && $past(q) < p
    |-> q == $past(q) + 1'h1)
    else $error("up edge not counted");
  a_down_step: assert property (tk && hold && !ue && de && $past(q) != '0
    |-> q == $past(q) - 1'h1)
    else $error("down edge not counted");
  a_top_down: assert property (tk && hold && ue && de && $past(q) == p
    && p != '0 |-> q == $past(q) - 1'h1)
    else $error("down at preset not applied");
  a_no_edge: assert property (tk && hold && !ue && !de |-> q == $past(q))
    else $error("count without edge");
  a_apb_answer: assert property ($rose(psel && penable) |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_tick_gap: assert property (tk |=> !tk [*3])
    else $error("intervals too close");
endmodule : logic_counter_bank_monitor

bind logic_counter_bank logic_counter_bank_monitor #(.N(N), .W(W)) mon (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .counter_ctrl(counter_ctrl), .counter_preset_value(counter_preset_value),
  .count_value_out(count_value_out), .at_zero_flag(at_zero_flag),
  .at_preset_flag(at_preset_flag), .interval_tick(interval_tick));

// ---- tb/ctrl_equation_model.sv ----
`timescale 1ns/100ps
module ctrl_equation_model #(
  parameter int N = 32,
  parameter int W = 16
) (
  // clock, reset and pacing
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic interval_tick,
  // equation results
  output logic_counter_bank_pkg::counter_ctrl_t [N-1:0] counter_ctrl,
  output logic [N-1:0][W-1:0] counter_preset_value
);
  int seed = 42742;
  logic [31:0] r;
  // fixed presets keep every count at or below its preset
  initial
  begin
    for (int i = 0; i < N; i++)
      counter_preset_value[i] = W'($random(seed) & 32'h0000_0007);
    counter_preset_value[5] = '0;
  end
  // levels settle just after each evaluation
  always @(posedge clk or posedge rst)
    if (rst)
      counter_ctrl <= '0;
    else if (interval_tick)
      for (int i = 0; i < N; i++)
      begin
        r = $random(seed);
        counter_ctrl[i] <= run ? {r[1:0] == 2'h0 && r[8],
          r[3:2] == 2'h0 && r[9], r[4], r[5]} : '0;
      end
endmodule : ctrl_equation_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) \
  begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h seen %0h", n, e, g); end end
module tb;
  localparam int N = logic_counter_bank_pkg::NUM_COUNTERS;
  localparam int W = logic_counter_bank_pkg::COUNT_W;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, run, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [N-1:0] variable_in, vt_out, lv_out, at_zero, at_preset, z, pm;
  logic [N-1:0] dis = '0, up_na = '0, dn_na = '0, pu = '0, pd = '0;
  logic_counter_bank_pkg::counter_ctrl_t [N-1:0] ctrl;
  logic [N-1:0][W-1:0] pv, cnt;
  logic [N-1:0][W-1:0] ex = '0;
  wire logic tick;
  int fail_count = 0;
  int checked = 0;
  logic_counter_bank #(.TICK_CYCLES(8)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_ctrl(ctrl), .counter_preset_value(pv),
    .variable_in(variable_in), .timer_pickup_delay({N{20'h00003}}),
    .timer_dropout_delay({N{20'h00003}}), .count_value_out(cnt),
    .at_zero_flag(at_zero), .at_preset_flag(at_preset),
    .logic_variable_out(lv_out), .variable_timer_out(vt_out),
    .interval_tick(tick));
  ctrl_equation_model model (.clk(clk), .rst(rst), .run(run),
    .interval_tick(tick), .counter_ctrl(ctrl), .counter_preset_value(pv));
  function logic [W-1:0] nxt(input logic [W-1:0] c, p,
    input logic clr, ld, ue, de);
    if (clr) return '0;
    if (ld) return p;
    // both edges at preset fall through to the down step
    if (ue && c < p) return c + 1'h1;
    if (de) return c != '0 ? c - 1'h1 : c;
    return c;
  endfunction : nxt
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task close_out;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // outputs are settled at the falling edge, inputs not yet moved
  always @(negedge clk)
    if (tick === 1'h1)
      for (int i = 0; i < N; i++)
      begin
        ex[i] = dis[i] || dn_na[i] ? '0 : nxt(ex[i], pv[i], ctrl[i].clear,
          ctrl[i].load, ctrl[i].up && !pu[i] && !up_na[i],
          ctrl[i].down && !pd[i]);
        pu[i] = ctrl[i].up;
        pd[i] = ctrl[i].down;
        `CHK("count", ex[i], cnt[i])
        `CHK("zero", ex[i] == '0, at_zero[i])
        `CHK("preset", !dis[i] && !dn_na[i] && ex[i] == pv[i], at_preset[i])
      end
  initial
  begin
    {rst, psel, penable, pwrite, run} = 5'h10;
    {paddr, pwdata, variable_in} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    apb(1'h1, logic_counter_bank_pkg::ADDR_DISABLE, 32'h0000_0002);
    apb(1'h1, logic_counter_bank_pkg::ADDR_DOWN_NA, 32'h0000_0004);
    apb(1'h1, logic_counter_bank_pkg::ADDR_UP_NA, 32'h0000_0008);
    {dis, dn_na, up_na} = {32'h0000_0002, 32'h0000_0004, 32'h0000_0008};
    apb(1'h0, logic_counter_bank_pkg::ADDR_UP_NA, 32'h0000_0000);
    `CHK("up_na", 32'h0000_0008, rd)
    apb(1'h0, 32'h0000_0040, 32'h0000_0000);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    $display("test registers done");
    variable_in <= '1;
    run <= 1'h1;
    repeat (1600) @(posedge clk);
    `CHK("timer", 32'hFFFF_FFFF, vt_out)
    `CHK("variable", 32'hFFFF_FFFF, lv_out)
    apb(1'h1, logic_counter_bank_pkg::ADDR_STATUS, 32'h0000_0001);
    apb(1'h0, logic_counter_bank_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK("status_clear", 1'h0, rd[0])
    apb(1'h1, logic_counter_bank_pkg::ADDR_CTRL, 32'h0000_0001);
    @(posedge clk);
    @(negedge clk);
    `CHK("timer_clear", 32'h0000_0000, vt_out)
    `CHK("variable_clear", 32'h0000_0000, lv_out)
    apb(1'h0, logic_counter_bank_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK("cleared", 1'h1, rd[0])
    $display("test variables done");
    run <= 1'h0;
    repeat (40) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, logic_counter_bank_pkg::ADDR_QUERY_SEL, 32'(i));
      apb(1'h0, logic_counter_bank_pkg::ADDR_QUERY_VAL, 32'h0000_0000);
      `CHK("query", 32'(ex[i]), rd)
    end
    for (int i = 0; i < N; i++)
    begin
      z[i] = ex[i] == '0;
      pm[i] = !dis[i] && !dn_na[i] && ex[i] == pv[i];
    end
    apb(1'h0, logic_counter_bank_pkg::ADDR_AT_ZERO, 32'h0000_0000);
    `CHK("zero_reg", z, rd)
    apb(1'h0, logic_counter_bank_pkg::ADDR_AT_PRESET, 32'h0000_0000);
    `CHK("preset_reg", pm, rd)
    $display("test counters done");
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out;
  end
endmodule : tb
